//--- rtl/tbc_top.sv
// Purpose: trigger bit coincidence datapath from streams to trigger bits
// Assumes: streams synchronous to clock_i, settings static during a run
// Notes: decision latency is fixed by structure plus delay/latency settings
`timescale 1ns/10ps
`default_nettype none
`include "tbc_params.svh"
module tbc_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // run control: high holds the run stopped
  input wire logic sync_i,
  // upstream streams
  input wire logic [`TBC_NSTREAM-1:0] stream_valid_i,
  input wire logic [`TBC_NSTREAM-1:0][`TBC_DW-1:0] stream_data_i,
  output logic [`TBC_NSTREAM-1:0] stream_ready_o,
  // stream conditioning settings
  input wire logic [`TBC_NSTREAM-1:0][`TBC_DLY_W-1:0] delay_i,
  input wire logic [`TBC_NHIT-1:0][`TBC_EXT_W-1:0] hit_ext_i,
  input wire logic [1:0][`TBC_WIN_W-1:0] window_i,
  // trigger bit settings
  input wire logic [`TBC_NBITS-1:0][`TBC_NTERM-1:0][`TBC_DW-1:0] thresh_i,
  input wire logic [`TBC_NBITS-1:0][`TBC_NTERM-1:0][`TBC_DW-1:0] mask_i,
  input wire logic [`TBC_NBITS-1:0][`TBC_NTERM-1:0][`TBC_SCALE_W-1:0] scale_i,
  input wire logic [`TBC_NBITS-1:0][`TBC_NTERM-1:0] select_i,
  input wire logic [`TBC_NBITS-1:0][`TBC_EXT_W-1:0] bit_ext_i,
  input wire logic [`TBC_NBITS-1:0][`TBC_LAT_W-1:0] bit_lat_i,
  // results and status
  output logic [`TBC_NBITS-1:0] trig_o,
  output logic run_o,
  output logic underrun_o
);
  localparam int PW = `TBC_DW + `TBC_SCALE_W;

  // ****************************************
  // helpers
  // ****************************************
  // mask, scale, then threshold one subsystem value
  function automatic logic term_hit(input logic [`TBC_DW-1:0] v, input logic [`TBC_DW-1:0] m,
                                    input logic [`TBC_SCALE_W-1:0] s, input logic [`TBC_DW-1:0] t);
    logic [PW-1:0] prod;
    prod = PW'(v & m) * PW'(s);
    return prod >= PW'(t);
  endfunction

  // ****************************************
  // run sequencing
  // ****************************************
  tbc_pkg::tbc_run_e state_q, state_d;
  logic [3:0] wait_q;
  logic run_q, under_q;
  wire idle_w = state_q == tbc_pkg::TBC_IDLE;
  wire pop_w = state_q == tbc_pkg::TBC_RUN;
  wire wait_done_w = wait_q == 4'(`TBC_SYNC_WAIT - 1);
  logic [`TBC_NSTREAM-1:0] fvalid_w;
  logic [`TBC_NSTREAM-1:0][`TBC_DW-1:0] fdata_w;

  // fill for a fixed count so every stream has words queued before the common read
  always_comb begin
    state_d = state_q;
    case (state_q)
      tbc_pkg::TBC_IDLE: begin
        if (!sync_i) begin
          state_d = tbc_pkg::TBC_FILL;
        end
      end
      tbc_pkg::TBC_FILL: begin
        if (sync_i) begin
          state_d = tbc_pkg::TBC_IDLE;
        end else if (wait_done_w) begin
          state_d = tbc_pkg::TBC_RUN;
        end
      end
      tbc_pkg::TBC_RUN: begin
        if (sync_i) begin
          state_d = tbc_pkg::TBC_IDLE;
        end
      end
      default: state_d = tbc_pkg::TBC_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= tbc_pkg::TBC_IDLE;
      wait_q <= 4'h0;
      run_q <= 1'b0;
      under_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= (state_q == tbc_pkg::TBC_FILL) ? wait_q + 4'h1 : 4'h0;
      run_q <= state_d == tbc_pkg::TBC_RUN;
      under_q <= !idle_w && (under_q || (pop_w && !(&fvalid_w))); // sticky until stop
    end
  end

  assign run_o = run_q;
  assign underrun_o = under_q;

  // ****************************************
  // input fifos and deskew
  // ****************************************
  logic [`TBC_NSTREAM-1:0][`TBC_DW-1:0] dly_q;

  generate
    for (genvar s = 0; s < `TBC_NSTREAM; s++) begin : g_stream
      tbc_stream_if #(.W(`TBC_DW)) lnk ();
      logic [`TBC_DW-1:0] hist_q [`TBC_DLY_DEPTH];
      wire [`TBC_DW-1:0] src_w = fvalid_w[s] ? fdata_w[s] : '0; // empty fifo reads as zero
      wire [`TBC_DW-1:0] tap_w = (delay_i[s] == '0) ? src_w : hist_q[delay_i[s] - `TBC_DLY_W'(1)];

      // one word per cycle per stream is accepted into its own fifo
      assign lnk.in_valid = stream_valid_i[s];
      assign lnk.in_data = stream_data_i[s];
      assign lnk.out_ready = pop_w;
      assign stream_ready_o[s] = lnk.in_ready;
      assign fvalid_w[s] = lnk.out_valid;
      assign fdata_w[s] = lnk.out_data;

      tbc_fifo #(.W(`TBC_DW), .D(`TBC_FIFO_DEPTH)) u_fifo (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .flush_i (idle_w),
        .lnk (lnk.fifo_side)
      );

      // private delay line per stream; its tap is set only by this stream's setting
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          for (int k = 0; k < `TBC_DLY_DEPTH; k++) begin
            hist_q[k] <= '0;
          end
          dly_q[s] <= '0;
        end else begin
          hist_q[0] <= src_w;
          for (int k = 1; k < `TBC_DLY_DEPTH; k++) begin
            hist_q[k] <= hist_q[k-1];
          end
          dly_q[s] <= tap_w;
        end
      end
    end
  endgenerate

  // ****************************************
  // conditioning
  // ****************************************
  // sum wraps at 32 bits; upstream must keep the two halves small enough
  wire [`TBC_DW-1:0] fwd_sum_w = `TBC_DW'(dly_q[`TBC_S_FWD_A] + dly_q[`TBC_S_FWD_B]);
  wire [1:0][`TBC_DW-1:0] energy_w = {fwd_sum_w, dly_q[`TBC_S_BARREL]};
  logic [`TBC_NTERM-1:0][`TBC_DW-1:0] cond_w;

  generate
    for (genvar e = 0; e < 2; e++) begin : g_energy
      logic [`TBC_DW-1:0] ihist_q [`TBC_WIN_DEPTH];
      logic [`TBC_DW-1:0] isum_q;
      // running sum of the last window+1 words; cleared while stopped
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          for (int k = 0; k < `TBC_WIN_DEPTH; k++) begin
            ihist_q[k] <= '0;
          end
          isum_q <= '0;
        end else if (idle_w) begin
          for (int k = 0; k < `TBC_WIN_DEPTH; k++) begin
            ihist_q[k] <= '0;
          end
          isum_q <= '0;
        end else begin
          ihist_q[0] <= energy_w[e];
          for (int k = 1; k < `TBC_WIN_DEPTH; k++) begin
            ihist_q[k] <= ihist_q[k-1];
          end
          isum_q <= `TBC_DW'(isum_q + energy_w[e] - ihist_q[window_i[e]]);
        end
      end
      assign cond_w[e] = isum_q;
    end

    for (genvar h = 0; h < `TBC_NHIT; h++) begin : g_hit
      logic [`TBC_DW-1:0] hold_q;
      logic [`TBC_EXT_W-1:0] cnt_q;
      wire [`TBC_DW-1:0] in_w = dly_q[`TBC_S_HIT0 + h];
      // a nonzero hit pattern is held for extension+1 cycles
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          hold_q <= '0;
          cnt_q <= '0;
        end else if (in_w != '0) begin
          hold_q <= in_w;
          cnt_q <= hit_ext_i[h];
        end else if (cnt_q != '0) begin
          cnt_q <= cnt_q - `TBC_EXT_W'(1);
        end else begin
          hold_q <= '0;
        end
      end
      assign cond_w[`TBC_T_HIT0 + h] = hold_q;
    end
  endgenerate

  // ****************************************
  // trigger bits
  // ****************************************
  // thirty identical slices all read the same cond_w copy each cycle
  generate
    for (genvar b = 0; b < `TBC_NBITS; b++) begin : g_bit
      logic [`TBC_NTERM-1:0] term_q;
      logic [`TBC_EXT_W-1:0] ext_q;
      logic on_q, out_q;
      logic [`TBC_LAT_DEPTH-1:0] lat_q;
      wire [`TBC_NTERM-1:0] term_w;
      wire coinc_w = (|select_i[b]) && (&(term_q | ~select_i[b]));
      wire lat_tap_w = (bit_lat_i[b] == '0) ? on_q : lat_q[bit_lat_i[b] - `TBC_LAT_W'(1)];

      for (genvar t = 0; t < `TBC_NTERM; t++) begin : g_term
        assign term_w[t] = term_hit(cond_w[t], mask_i[b][t], scale_i[b][t], thresh_i[b][t]);
      end

      // fixed stage count per slice keeps the latency independent of data
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          term_q <= '0;
          ext_q <= '0;
          on_q <= 1'b0;
          lat_q <= '0;
          out_q <= 1'b0;
        end else begin
          term_q <= term_w;
          if (coinc_w) begin
            on_q <= 1'b1;
            ext_q <= bit_ext_i[b];
          end else if (ext_q != '0) begin
            on_q <= 1'b1;
            ext_q <= ext_q - `TBC_EXT_W'(1);
          end else begin
            on_q <= 1'b0;
          end
          lat_q <= {lat_q[`TBC_LAT_DEPTH-2:0], on_q};
          out_q <= lat_tap_w;
        end
      end
      assign trig_o[b] = out_q;
    end
  endgenerate

  // settings are sampled live; changing them mid-run breaks alignment
endmodule
`default_nettype wire

//--- shared/tbc_params.svh
// Purpose: constants of the trigger bit coincidence datapath
// Assumes: one clock, all streams 32 bits wide
// Notes: widths and depths are fixed, not parameters
`ifndef TBC_PARAMS_SVH
`define TBC_PARAMS_SVH

// ****************************************
// sizes
// ****************************************
`define TBC_DW 32
`define TBC_NSTREAM 8
`define TBC_NTERM 7
`define TBC_NHIT 5
`define TBC_NBITS 30
`define TBC_FIFO_DEPTH 8
`define TBC_DLY_W 5
`define TBC_DLY_DEPTH 32
`define TBC_WIN_W 4
`define TBC_WIN_DEPTH 16
`define TBC_EXT_W 8
`define TBC_SCALE_W 4
`define TBC_LAT_W 4
`define TBC_LAT_DEPTH 16

// ****************************************
// stream and term positions
// ****************************************
`define TBC_S_BARREL 0
`define TBC_S_FWD_A 1
`define TBC_S_FWD_B 2
`define TBC_S_HIT0 3
`define TBC_T_BARREL 0
`define TBC_T_FWD 1
`define TBC_T_HIT0 2

// ****************************************
// timing counts
// ****************************************
`define TBC_SYNC_WAIT 4
`define TBC_CLK_MHZ 100

`endif

//--- shared/tbc_pkg.sv
// Purpose: types of the trigger bit coincidence datapath
// Assumes: nothing beyond the params header
// Notes: constants live in tbc_params.svh
`default_nettype none
package tbc_pkg;
  typedef logic [31:0] tbc_word_t;
  typedef enum logic [1:0] {
    TBC_IDLE,
    TBC_FILL,
    TBC_RUN
  } tbc_run_e;
endpackage
`default_nettype wire

//--- shared/tbc_stream_if.sv
// Purpose: valid/ready word carrier between top and stream fifo
// Assumes: one clock domain
// Notes: fifo_side faces the fifo, user_side faces the top
`timescale 1ns/10ps
`default_nettype none
interface tbc_stream_if #(parameter int W = 32);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo_side (input in_valid, input in_data, input out_ready,
                     output in_ready, output out_valid, output out_data);
  modport user_side (output in_valid, output in_data, output out_ready,
                     input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

//--- rtl/tbc_fifo.sv
// Purpose: small show-ahead fifo with registered read data
// Assumes: single clock, synchronous flush
// Notes: ready and head data come from flip-flops
`timescale 1ns/10ps
`default_nettype none
module tbc_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // control
  input wire logic flush_i,
  // stream carrier
  tbc_stream_if.fifo_side lnk
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic rdy_q, vld_q;
  logic [W-1:0] head_q;
  wire push = lnk.in_valid && rdy_q;
  wire pop = lnk.out_ready && vld_q;
  wire [AW-1:0] wr_nx = (wr_q == AW'(D - 1)) ? '0 : wr_q + AW'(1);
  wire [AW-1:0] rd_nx = (rd_q == AW'(D - 1)) ? '0 : rd_q + AW'(1);

  // pointer and count updates
  assign rd_d = pop ? rd_nx : rd_q;
  assign cnt_d = flush_i ? '0 : CW'(cnt_q + CW'(push) - CW'(pop));
  assign lnk.in_ready = rdy_q;
  assign lnk.out_valid = vld_q;
  assign lnk.out_data = head_q;

  // storage, no reset needed on the array
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= lnk.in_data;
    end
  end

  // head register bypasses the array when the write lands on the new head
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
      head_q <= '0;
    end else begin
      wr_q <= flush_i ? '0 : (push ? wr_nx : wr_q);
      rd_q <= flush_i ? '0 : rd_d;
      cnt_q <= cnt_d;
      rdy_q <= !flush_i && (cnt_d != FULL);
      vld_q <= cnt_d != '0;
      head_q <= (push && wr_q == rd_d) ? lnk.in_data : mem_q[rd_d];
    end
  end
endmodule
`default_nettype wire

//--- verif/tbc_upstream.sv
// Purpose: upstream subsystem processor model feeding the eight streams
// Assumes: one word per stream per clock while offering
// Notes: holding back words is its only fault, and only when the bench asks
`timescale 1ns/10ps
`default_nettype none
`include "tbc_params.svh"
module tbc_upstream (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // bench control
  input wire logic hold_i,
  input wire logic [`TBC_NSTREAM-1:0][`TBC_DW-1:0] word_i,
  // stream side
  output logic [`TBC_NSTREAM-1:0] valid_o,
  output logic [`TBC_NSTREAM-1:0][`TBC_DW-1:0] data_o
);
  // a held-back line shows the inverse, so a stale word never reads as fresh
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= '0;
      data_o <= '0;
    end else if (hold_i) begin
      valid_o <= '0;
      data_o <= ~data_o;
    end else begin
      valid_o <= '1;
      data_o <= word_i;
    end
  end
endmodule
`default_nettype wire

//--- verif/tbc_props.sv
// Purpose: port-level checks on the trigger datapath
// Assumes: settings static during a run
// Notes: attached by bind at the foot
`timescale 1ns/10ps
`default_nettype none
`include "tbc_params.svh"
module tbc_props (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic sync_i,
  input wire logic [`TBC_NBITS-1:0][`TBC_NTERM-1:0] select_i,
  input wire logic [`TBC_NBITS-1:0][`TBC_EXT_W-1:0] bit_ext_i,
  input wire logic [`TBC_NSTREAM-1:0] stream_ready_o,
  input wire logic [`TBC_NBITS-1:0] trig_o,
  input wire logic run_o,
  input wire logic underrun_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // run control
  // ****************************************
  a_stop_no_ready: assert property (sync_i [*3] |-> stream_ready_o == 8'h00 && !run_o)
    else $error("ready or run while stopped");
  a_start_wait_min: assert property ($fell(sync_i) |-> !run_o [*4])
    else $error("run began before fill wait");
  a_start_wait_max: assert property ($fell(sync_i) ##1 !sync_i [*8] |-> run_o)
    else $error("run did not begin");
  a_run_no_stall: assert property (run_o && !sync_i |=> run_o)
    else $error("run dropped without stop");
  a_run_ready_all: assert property (run_o && !sync_i |-> stream_ready_o == 8'hFF)
    else $error("stream refused during run");
  a_underrun_keep: assert property (underrun_o && !sync_i |=> underrun_o)
    else $error("underrun flag lost");
  a_underrun_cause: assert property ($rose(underrun_o) |-> run_o || $past(run_o))
    else $error("underrun outside run");
  // decision side
  a_unsel_silent: assert property (select_i[29] == 7'h00 |-> !trig_o[29])
    else $error("unselected bit fired");
  a_bit_stretch: assert property ($rose(trig_o[0]) && bit_ext_i[0] == 8'h03 |-> trig_o[0] [*4])
    else $error("bit stretch too short");
  c_run_start: cover property ($rose(run_o));
  c_underrun: cover property ($rose(underrun_o));
  c_coincide: cover property ($rose(trig_o[1]));
endmodule
bind tbc_top tbc_props tbc_props_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .sync_i(sync_i),
  .select_i(select_i), .bit_ext_i(bit_ext_i), .stream_ready_o(stream_ready_o), .trig_o(trig_o),
  .run_o(run_o), .underrun_o(underrun_o));
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for the trigger datapath and its fifo
// Assumes: latency compared relative to the first decision seen
// Notes: bits 0..3 carry the scenarios, the rest stay unselected
`timescale 1ns/10ps
`default_nettype none
`include "tbc_params.svh"
module tb_top;
  typedef struct {int t; int extra; int width; logic [3:0] mask;} tbc_note_s;
  localparam int TM[4] = '{2, 3, 0, 1};
  localparam int SC[4] = '{1, 1, 2, 1};
  localparam int TH[4] = '{1, 1, 100, 256};
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sync_i = 1'b1;
  logic hold = 1'b0;
  // streams 0..4 carry the scenarios, 5..7 carry noise
  logic [4:0][`TBC_DW-1:0] words = '0;
  logic [2:0][`TBC_DW-1:0] noise = '0;
  logic [`TBC_NSTREAM-1:0] valid, ready;
  logic [`TBC_NSTREAM-1:0][`TBC_DW-1:0] data;
  logic [`TBC_NSTREAM-1:0][`TBC_DLY_W-1:0] dly = '0;
  logic [`TBC_NHIT-1:0][`TBC_EXT_W-1:0] hext = '0;
  logic [1:0][`TBC_WIN_W-1:0] win = '0;
  logic [`TBC_NBITS-1:0][`TBC_NTERM-1:0][`TBC_DW-1:0] thr = '0, msk = '1;
  logic [`TBC_NBITS-1:0][`TBC_NTERM-1:0][`TBC_SCALE_W-1:0] scl = '0;
  logic [`TBC_NBITS-1:0][`TBC_NTERM-1:0] sel = '0;
  logic [`TBC_NBITS-1:0][`TBC_EXT_W-1:0] bext = '0;
  logic [`TBC_NBITS-1:0][`TBC_LAT_W-1:0] blat = '0;
  logic [`TBC_NBITS-1:0] trig;
  logic run, underrun, prev0 = 1'b0;
  logic [3:0] fired = 4'h0;
  logic [`TBC_NBITS-5:0] spare_hits = '0;
  int cyc = 0, fails = 0, total_checks = 0, base = -1, rise = 0, width = 0;
  tbc_note_s notes[$];
  tbc_note_s n;
  tbc_top tbc_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .sync_i(sync_i), .stream_valid_i(valid),
    .stream_data_i(data), .stream_ready_o(ready), .delay_i(dly), .hit_ext_i(hext), .window_i(win),
    .thresh_i(thr), .mask_i(msk), .scale_i(scl), .select_i(sel), .bit_ext_i(bext), .bit_lat_i(blat),
    .trig_o(trig), .run_o(run), .underrun_o(underrun));
  tbc_upstream tbc_upstream_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .hold_i(hold), .word_i({noise, words}),
    .valid_o(valid), .data_o(data));
  // ****************************************
  // clock, noise and checks
  // ****************************************
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) cyc <= cyc + 1;
  // random words on unselected streams must never sway a decision
  always @(negedge clock_i) begin
    noise <= {$urandom, $urandom, $urandom};
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one note per decision on bit 0, taken when its pulse ends
  always @(negedge clock_i) begin
    if (trig[0] === 1'b1 && prev0 !== 1'b1) begin
      rise = cyc;
      width = 0;
      fired = 4'h0;
    end
    if (trig[0] === 1'b1) width++;
    fired = fired | trig[3:0];
    // unselected bits must stay quiet for the whole run
    spare_hits = spare_hits | trig[`TBC_NBITS-1:4];
    if (trig[0] !== 1'b1 && prev0 === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      if (base < 0) base = rise - n.t - n.extra;
      chk_word(rise - n.t - n.extra, base);
      chk_word(width, n.width);
      chk_word(32'(fired), 32'(n.mask));
    end
    prev0 = trig[0];
  end
  initial begin
    #(5000 * 10);
    fails++;
    wrap_up();
  end
  // ****************************************
  // scenarios
  // ****************************************
  // settings change only while stopped
  task automatic start_run(input int d, input int d4, input int h, input int b, input int lat, input int w0);
    sync_i = 1'b1;
    repeat (4) @(negedge clock_i);
    chk_flag(underrun, 1'b0);
    chk_word(32'(ready), 32'h0000_0000);
    for (int s = 0; s < 8; s++) dly[s] = (s == 4) ? d4[4:0] : d[4:0];
    hext = {5{h[7:0]}};
    win = {2{w0[3:0]}};
    for (int i = 0; i < 30; i++) begin
      bext[i] = (i == 0) ? b[7:0] : 8'h00;
      blat[i] = lat[3:0];
    end
    @(negedge clock_i);
    sync_i = 1'b0;
    // fifos stay flushed through the edge that leaves idle, then open together
    @(negedge clock_i);
    chk_word(32'(ready), 32'h0000_0000);
    @(negedge clock_i);
    chk_word(32'(ready), 32'h0000_00FF);
    for (int i = 0; i < 50 && run !== 1'b1; i++) @(negedge clock_i);
    chk_flag(run, 1'b1);
    chk_word(32'(ready), 32'h0000_00FF);
    repeat (10) @(negedge clock_i);
  endtask
  // barrel held four cycles, forward words and stream 3 hit on the last, stream 4 hit (if h4) off4 cycles earlier
  task automatic shot(input logic [31:0] bw, input logic [31:0] fa, input logic [31:0] fb, input int off4,
                      input logic h4, input logic [3:0] mask);
    for (int k = 0; k < 4; k++) begin
      @(negedge clock_i);
      words[0] = bw;
      words[1] = (k == 3) ? fa : 32'h0000_0000;
      words[2] = (k == 3) ? fb : 32'h0000_0000;
      words[3] = (k == 3) ? 32'h0000_0001 : 32'h0000_0000;
      words[4] = (k == 3 - off4 && h4) ? 32'h0000_0001 : 32'h0000_0000;
    end
    notes.push_back('{cyc, dly[3] + blat[0], hext[0] + 1 + bext[0], mask});
    @(negedge clock_i);
    words[4:0] = '0;
    repeat (40) @(negedge clock_i);
  endtask
  initial begin
    void'($urandom(32693));
    for (int i = 0; i < 4; i++) begin
      sel[i][2] = 1'b1;
      sel[i][TM[i]] = 1'b1;
      scl[i][2] = 4'h1;
      scl[i][TM[i]] = 4'(SC[i]);
      thr[i][2] = 32'h0000_0001;
      thr[i][TM[i]] = 32'(TH[i]);
    end
    repeat (4) @(negedge clock_i);
    rst_n_i = 1'b1;
    start_run(0, 0, 0, 0, 0, 0);
    shot(32'h0000_0032, 32'h0000_0080, 32'h0000_0080, 0, 1'b1, 4'hF);
    shot(32'h0000_0019, 32'h0000_0080, 32'h0000_0000, 0, 1'b0, 4'h1);
    start_run(3, 5, 2, 3, 4, 3);
    shot(32'h0000_0019, 32'h0000_0090, 32'h0000_0070, 2, 1'b1, 4'hF);
    shot(32'h0000_0000, 32'h0000_00FF, 32'h0000_0000, 2, 1'b0, 4'h1);
    // a gap shorter than the fill margin must be absorbed by the queued words
    hold = 1'b1;
    repeat (`TBC_SYNC_WAIT - 2) @(negedge clock_i);
    hold = 1'b0;
    repeat (3) @(negedge clock_i);
    chk_flag(underrun, 1'b0);
    chk_word(32'(ready), 32'h0000_00FF);
    // starve every fifo until empty
    hold = 1'b1;
    repeat (10) @(negedge clock_i);
    chk_word(32'(ready), 32'h0000_00FF);
    hold = 1'b0;
    repeat (3) @(negedge clock_i);
    chk_flag(underrun, 1'b1);
    chk_flag(run, 1'b1);
    sync_i = 1'b1;
    repeat (60) @(negedge clock_i);
    chk_flag(underrun, 1'b0);
    chk_word(notes.size(), 32'h0000_0000);
    chk_word(32'(spare_hits), 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
